// ===== design/mac_acc_pkg.sv
// Constants, encodings and carriers for the accumulator datapath slice.
// Assumes a 32-bit AXI4-Lite master that has already resolved operand words.
package mac_acc_pkg;

	// ****************************************************************
	// Widths and arithmetic constants
	// ****************************************************************
	localparam int          ACC_W       = 40;
	localparam int          ADDR_W      = 6;
	localparam logic [39:0] ROUND_CONST = 40'h0000008000;
	localparam logic [39:0] SAT_MAX     = 40'h007fffffff;
	localparam logic [39:0] SAT_MIN     = 40'hff80000000;
	localparam logic [4:0]  MAX_SHIFT   = 5'h10;

	// ****************************************************************
	// Register offsets (byte addresses)
	// ****************************************************************
	localparam logic [5:0] REG_CTRL   = 6'h00;
	localparam logic [5:0] REG_OPW    = 6'h04;
	localparam logic [5:0] REG_INSTR  = 6'h08;
	localparam logic [5:0] REG_ACC_LO = 6'h0c;
	localparam logic [5:0] REG_ACC_HI = 6'h10;
	localparam logic [5:0] REG_FLAGS  = 6'h14;

	// Field positions
	localparam int CTRL_SAT_BIT  = 0;
	localparam int FLAGS_BAD_BIT = 7;

	// Reset values
	localparam logic [39:0] ACC_RST   = 40'h0000000000;
	localparam logic [31:0] INSTR_RST = 32'h00000000;

	// ****************************************************************
	// Instruction encodings (first byte in bits 7:0)
	// ****************************************************************
	localparam logic [7:0] OPC_REG_REG = 8'ha3;
	localparam logic [7:0] OPC_REG_IND = 8'h83;
	localparam logic [7:0] OPC_IDX_IND = 8'h93;
	localparam logic [7:0] FN_ADD2     = 8'h42;
	localparam logic [7:0] FN_RND_IMM  = 8'hb2;
	localparam logic [7:0] FN_RND_REG  = 8'hba;
	localparam logic [7:0] FN_TRN_IMM  = 8'ha2;
	localparam logic [7:0] FN_TRN_REG  = 8'haa;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		INS_NONE = 2'b00,
		INS_ADD2 = 2'b01,
		INS_RND  = 2'b10,
		INS_TRN  = 2'b11
	} instr_e;

	typedef struct packed {
		logic neg;
		logic zero;
		logic carry;
		logic sov;
		logic ext;
		logic ssat;
		logic ov;
	} flags_s;

	localparam flags_s FLAGS_RST = '0;

endpackage

// ===== design/mac_accumulator_add2_shift.sv
// Accumulator datapath: doubled add and arithmetic right shifts on 40 bits.
// Assumes an AXI4-Lite master on aclk; writing the instruction register runs it.
//
// Functional notes
// - Doubled add sign-extends high:low words to 40 bits, doubles, adds.
// - Doubled add sets overflow if true sum exceeds 40-bit signed range.
// - Sticky saturation flag set on clamping, otherwise kept.
// - Extension-used flag follows whether result uses the extension bits.
// - Add and rounding shift set sticky overflow on overflow, else keep.
// - Doubled add carry flag is the 40-bit carry out.
// - Zero flag set when the 40-bit result is zero.
// - Negative flag copies bit 39 of the result.
// - Shifts move right per count, replicating the original sign bit.
// - Rounding shift adds bit-15 constant after shifting.
// - Shift count 0..16; immediate is a 5-bit unsigned field.
// - Register count uses only its four low bits, 0..15.
// - Rounding shift carry flag is the rounding carry out.
// - Rounding shift overflow flag follows overflow; result may saturate.
// - Non-rounding shift never saturates.
// - Non-rounding shift clears overflow and carry, keeps sticky flags.
`timescale 1ns/10ps
module mac_accumulator_add2_shift
	import mac_acc_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready
);

	// ****************************************************************
	// State
	// ****************************************************************
	logic [39:0]       accumulator, next_accumulator;
	flags_s            flags, next_flags;
	logic              bad_instr, next_bad_instr;
	logic              saturation_mode_bit, next_saturation_mode_bit;
	logic [31:0]       opw, next_opw;
	logic [31:0]       instr, next_instr;
	logic              aw_full, next_aw_full;
	logic              w_full, next_w_full;
	logic [ADDR_W-1:0] aw_addr, next_aw_addr;
	logic [31:0]       w_data, next_w_data;
	logic [3:0]        w_strb, next_w_strb;
	logic              next_bvalid;
	logic [1:0]        next_bresp;
	logic              next_rvalid;
	logic [31:0]       next_rdata;
	logic [1:0]        next_rresp;
	// ****************************************************************
	// Decode
	// ****************************************************************
	logic        do_write;
	logic        exec;
	logic        wr_ok;
	instr_e      kind;
	logic [4:0]  cnt;
	logic        cnt_from_reg;
	logic [7:0]  b0, b1, b2, b3;
	logic [31:0] wmask;

	assign do_write = aw_full && w_full && !bvalid;
	assign {b3, b2, b1, b0} = w_data;

	always_comb
	begin
		kind = INS_NONE;
		cnt_from_reg = 1'b0;
		cnt = b3[4:0];
		if (b2 == FN_ADD2 && (b0 == OPC_REG_REG || b0 == OPC_REG_IND || b0 == OPC_IDX_IND))
			kind = INS_ADD2;
		else if (b0 == OPC_REG_REG && b1 == 8'h00 && (b2 == FN_RND_IMM || b2 == FN_TRN_IMM))
			kind = (b2 == FN_RND_IMM) ? INS_RND : INS_TRN;
		else if ((b0 == OPC_REG_REG || b0 == OPC_REG_IND) && (b2 == FN_RND_REG || b2 == FN_TRN_REG))
		begin
			kind = (b2 == FN_RND_REG) ? INS_RND : INS_TRN;
			cnt_from_reg = 1'b1;
			cnt = {1'b0, opw[3:0]};
		end
		// Immediate counts above 16 are refused rather than wrapped
		if (!cnt_from_reg && kind != INS_ADD2 && b3[4:0] > MAX_SHIFT)
			kind = INS_NONE;
	end
	assign wr_ok = (aw_addr != REG_INSTR) || (w_strb == 4'hf);
	assign exec  = do_write && aw_addr == REG_INSTR && wr_ok && kind != INS_NONE;

	// ****************************************************************
	// Arithmetic
	// ****************************************************************
	logic [39:0] operand, shifted, result;
	logic [41:0] add_true, rnd_true, true_v;
	logic [40:0] add_raw, rnd_raw;
	logic        ovf, sat_hit;
	flags_s      res_flags;

	assign operand  = {{8{opw[31]}}, opw};
	assign add_true = {{2{accumulator[39]}}, accumulator} + {operand[39], operand, 1'b0};
	assign add_raw  = {1'b0, accumulator} + {1'b0, operand[38:0], 1'b0};
	assign shifted  = 40'($signed(accumulator) >>> cnt);
	assign rnd_true = {{2{shifted[39]}}, shifted} + {2'b00, ROUND_CONST};
	assign rnd_raw  = {1'b0, shifted} + {1'b0, ROUND_CONST};

	always_comb
	begin
		case (kind)
			INS_ADD2: true_v = add_true;
			INS_RND:  true_v = rnd_true;
			default:  true_v = {{2{shifted[39]}}, shifted};
		endcase
		ovf = (true_v[41:39] != 3'b000) && (true_v[41:39] != 3'b111);
		// Non-rounding shift ignores saturation mode
		sat_hit = saturation_mode_bit && kind != INS_TRN
			&& ($signed(true_v) > $signed({{2{SAT_MAX[39]}}, SAT_MAX})
			|| $signed(true_v) < $signed({{2{SAT_MIN[39]}}, SAT_MIN}));
		if (sat_hit)
			result = true_v[41] ? SAT_MIN : SAT_MAX;
		else
			result = true_v[39:0];
		res_flags.ov    = (kind == INS_TRN) ? 1'b0 : ovf;
		res_flags.ssat  = flags.ssat | sat_hit;
		res_flags.ext   = (result[39:31] != 9'h000) && (result[39:31] != 9'h1ff);
		res_flags.sov   = flags.sov | ((kind != INS_TRN) && ovf);
		case (kind)
			INS_ADD2: res_flags.carry = add_raw[40];
			INS_RND:  res_flags.carry = rnd_raw[40];
			default:  res_flags.carry = 1'b0;
		endcase
		res_flags.zero  = (result == 40'h0000000000);
		res_flags.neg   = result[39];
	end
	// ****************************************************************
	// Register file and bus
	// ****************************************************************
	for (genvar i = 0; i < 4; i++)
	begin : g_wmask
		assign wmask[i*8 +: 8] = {8{w_strb[i]}};
	end

	assign awready = !aw_full && !bvalid;
	assign wready  = !w_full && !bvalid;
	assign arready = !rvalid;
	logic addr_ok;
	assign addr_ok = (aw_addr == REG_CTRL) || (aw_addr == REG_OPW) || (aw_addr == REG_INSTR)
		|| (aw_addr == REG_ACC_LO) || (aw_addr == REG_ACC_HI) || (aw_addr == REG_FLAGS);
	always_comb
	begin
		next_accumulator         = accumulator;
		next_flags               = flags;
		next_bad_instr           = bad_instr;
		next_saturation_mode_bit = saturation_mode_bit;
		next_opw                 = opw;
		next_instr               = instr;
		next_aw_full             = aw_full;
		next_w_full              = w_full;
		next_aw_addr             = aw_addr;
		next_w_data              = w_data;
		next_w_strb              = w_strb;
		next_bvalid              = bvalid;
		next_bresp               = bresp;
		next_rvalid              = rvalid;
		next_rdata               = rdata;
		next_rresp               = rresp;
		if (awvalid && awready)
		begin
			next_aw_full = 1'b1;
			next_aw_addr = awaddr;
		end
		if (wvalid && wready)
		begin
			next_w_full = 1'b1;
			next_w_data = wdata;
			next_w_strb = wstrb;
		end
		if (bvalid && bready)
			next_bvalid = 1'b0;
		if (do_write)
		begin
			next_aw_full = 1'b0;
			next_w_full  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (addr_ok && wr_ok) ? RESP_OKAY : RESP_SLVERR;
			case (aw_addr)
				REG_CTRL:
					if (w_strb[0])
						next_saturation_mode_bit = w_data[CTRL_SAT_BIT];
				REG_OPW:
					next_opw = (opw & ~wmask) | (w_data & wmask);
				REG_ACC_LO:
					next_accumulator[31:0] = (accumulator[31:0] & ~wmask) | (w_data & wmask);
				REG_ACC_HI:
					if (w_strb[0])
						next_accumulator[39:32] = w_data[7:0];
				REG_FLAGS:
					if (w_strb[0])
						next_flags = flags_s'(w_data[6:0]);
				REG_INSTR:
					if (wr_ok)
					begin
						next_instr     = w_data;
						next_bad_instr = (kind == INS_NONE);
						// Result and flags land on the same edge
						if (exec)
						begin
							next_accumulator = result;
							next_flags       = res_flags;
						end
					end
				default:
					next_bresp = RESP_SLVERR;
			endcase
		end
		if (rvalid && rready)
			next_rvalid = 1'b0;
		if (arvalid && arready)
		begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			case (araddr)
				REG_CTRL:   next_rdata = {31'h0, saturation_mode_bit};
				REG_OPW:    next_rdata = opw;
				REG_INSTR:  next_rdata = instr;
				REG_ACC_LO: next_rdata = accumulator[31:0];
				REG_ACC_HI: next_rdata = {24'h0, accumulator[39:32]};
				REG_FLAGS:  next_rdata = {24'h0, bad_instr, flags};
				default:
				begin
					next_rdata = 32'h00000000;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			accumulator         <= ACC_RST;
			flags               <= FLAGS_RST;
			bad_instr           <= 1'b0;
			saturation_mode_bit <= 1'b0;
			opw                 <= 32'h00000000;
			instr               <= INSTR_RST;
			aw_full             <= 1'b0;
			w_full              <= 1'b0;
			aw_addr             <= '0;
			w_data              <= 32'h00000000;
			w_strb              <= 4'h0;
			bvalid              <= 1'b0;
			bresp               <= RESP_OKAY;
			rvalid              <= 1'b0;
			rdata               <= 32'h00000000;
			rresp               <= RESP_OKAY;
		end
		else
		begin
			accumulator         <= next_accumulator;
			flags               <= next_flags;
			bad_instr           <= next_bad_instr;
			saturation_mode_bit <= next_saturation_mode_bit;
			opw                 <= next_opw;
			instr               <= next_instr;
			aw_full             <= next_aw_full;
			w_full              <= next_w_full;
			aw_addr             <= next_aw_addr;
			w_data              <= next_w_data;
			w_strb              <= next_w_strb;
			bvalid              <= next_bvalid;
			bresp               <= next_bresp;
			rvalid              <= next_rvalid;
			rdata               <= next_rdata;
			rresp               <= next_rresp;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_add_value: assert property (exec && kind == INS_ADD2 && !sat_hit
		|=> accumulator == 40'($past(accumulator) + 2 * $past(operand)))
		else $error("doubled add result wrong");
	a_add_ovf: assert property (exec && kind == INS_ADD2
		|=> flags.ov == ($past(add_true) != {{2{$past(add_true[39])}}, $past(add_true[39:0])}))
		else $error("overflow flag wrong");
	a_sat_keep: assert property (exec && !sat_hit && !flags.ssat |=> !flags.ssat)
		else $error("saturation flag changed without clamping");
	a_ext_flag: assert property (exec
		|=> flags.ext == (accumulator[39:31] != 9'h000 && accumulator[39:31] != 9'h1ff))
		else $error("extension flag wrong");
	a_sov_set: assert property (exec && kind != INS_TRN && ovf |=> flags.sov)
		else $error("sticky overflow not set");
	a_zero_neg: assert property (exec
		|=> flags.zero == (accumulator == 40'h0) && flags.neg == accumulator[39])
		else $error("zero or negative flag wrong");
	a_trn_flags: assert property (exec && kind == INS_TRN
		|=> !flags.ov && !flags.carry && $stable(flags.sov) && $stable(flags.ssat))
		else $error("non-rounding shift flags wrong");
	a_reg_count: assert property (exec && kind == INS_TRN && cnt_from_reg
		|=> accumulator == 40'($signed($past(accumulator)) >>> $past(opw[3:0])))
		else $error("register count not limited to four bits");
	a_sat_clamp: assert property (exec && sat_hit
		|=> (accumulator == SAT_MAX || accumulator == SAT_MIN) && flags.ssat)
		else $error("saturation did not clamp");
	a_idle_hold: assert property (!do_write |=> $stable(accumulator) && $stable(flags))
		else $error("accumulator changed without an instruction");
	a_bresp_follow: assert property (do_write |=> bvalid [*1] ##0 !aw_full)
		else $error("write response missing");

	c_add2: cover property (exec && kind == INS_ADD2 && ovf);
	c_rnd_sat: cover property (exec && kind == INS_RND && sat_hit);
	c_trn16: cover property (exec && kind == INS_TRN && cnt == MAX_SHIFT);
	c_bad: cover property (do_write && aw_addr == REG_INSTR && kind == INS_NONE);
endmodule // mac_accumulator_add2_shift

// ===== tb/host_core_model.sv
// Host core model: AXI4-Lite master that issues operand and instruction words.
// Assumes the bench top mac_accumulator_add2_shift_tb offers timed_out for hangs.
`timescale 1ns/10ps
module host_core_model
	import mac_acc_pkg::*;
(
	input  wire logic              aclk,
	output logic [ADDR_W-1:0]      awaddr,
	output logic                   awvalid,
	input  wire logic              awready,
	output logic [31:0]            wdata,
	output logic [3:0]             wstrb,
	output logic                   wvalid,
	input  wire logic              wready,
	input  wire logic [1:0]        bresp,
	input  wire logic              bvalid,
	output logic                   bready,
	output logic [ADDR_W-1:0]      araddr,
	output logic                   arvalid,
	input  wire logic              arready,
	input  wire logic [31:0]       rdata,
	input  wire logic [1:0]        rresp,
	input  wire logic              rvalid,
	output logic                   rready
);
	initial
	begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// Ready sampled at the falling edge: inputs only move at rising edges
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] resp);
		logic ta, tw, tk;
		resp = 2'bxx;
		tk = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50 && !tk; n++)
		begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tk = bvalid;
			resp = tk ? bresp : 2'bxx;
			@(posedge aclk);
			// Released payload is scrambled so stale values never look valid
			if (ta) awvalid <= 1'b0;
			if (ta) awaddr <= ~a;
			if (tw) wvalid <= 1'b0;
			if (tw) wdata <= ~d;
			if (tk) bready <= 1'b0;
		end
		if (!tk) mac_accumulator_add2_shift_tb.timed_out();
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic ta, tk;
		tk = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50 && !tk; n++)
		begin
			@(negedge aclk);
			ta = arvalid & arready;
			tk = rvalid;
			d = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (ta) araddr <= ~a;
			if (tk) rready <= 1'b0;
		end
		if (!tk) mac_accumulator_add2_shift_tb.timed_out();
	endtask
endmodule // host_core_model

// ===== tb/mac_accumulator_add2_shift_tb.sv
// Self-checking bench for the accumulator doubled add and right shifts.
// Assumes host_core_model drives the register bus; expectations come from a local model.
`timescale 1ns/10ps
module mac_accumulator_add2_shift_tb
	import mac_acc_pkg::*;
	;
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic [31:0]       wdata, rdata, rd_v;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, rs;
	int                err_total = 0;
	int                num_checks = 0;

	always #12.5 aclk = ~aclk;

	mac_accumulator_add2_shift i_mac_accumulator_add2_shift (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready);
	host_core_model i_host_core_model (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready);

	// ****************************************************************
	// Reporting and bus helpers
	// ****************************************************************
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d, errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic timed_out();
		err_total++;
		stop_test();
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		i_host_core_model.wr(a, d, 4'hf, rs);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a);
		i_host_core_model.rd(a, rd_v, rs);
	endtask

	// Loads state, executes one instruction, compares with the local model
	task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
		input logic [4:0] imm, input logic [39:0] a, input logic [31:0] op, input logic sat,
		input logic [6:0] f0);
		logic signed [41:0] t;
		logic [40:0]        c;
		logic [39:0]        sh, r, got;
		logic [4:0]         n;
		logic [6:0]         f;
		logic               trn, s;
		f = f0;
		trn = (b2 == FN_TRN_IMM) || (b2 == FN_TRN_REG);
		n = (b2 == FN_RND_IMM || b2 == FN_TRN_IMM) ? imm : {1'b0, op[3:0]};
		sh = $signed(a) >>> n;
		t = $signed({{2{sh[39]}}, sh});
		c = '0;
		if (b2 == FN_ADD2)
			t = $signed({{2{a[39]}}, a}) + $signed({{9{op[31]}}, op, 1'b0});
		if (b2 == FN_ADD2)
			c = {1'b0, a} + {1'b0, {7{op[31]}}, op, 1'b0};
		if (b2 == FN_RND_IMM || b2 == FN_RND_REG)
			t = t + 42'sh8000;
		if (b2 == FN_RND_IMM || b2 == FN_RND_REG)
			c = {1'b0, sh} + {1'b0, ROUND_CONST};
		s = sat && !trn && (t > $signed({2'b00, SAT_MAX}) || t < $signed({2'b11, SAT_MIN}));
		r = s ? (t[41] ? SAT_MIN : SAT_MAX) : t[39:0];
		f[0] = !trn && t[41:39] != 3'b000 && t[41:39] != 3'b111;
		f[1] = f[1] | s;
		f[2] = r[39:31] != 9'h000 && r[39:31] != 9'h1ff;
		if (!trn) f[3] = f[3] | f[0];
		f[4] = c[40];
		f[5] = r == 40'h0;
		f[6] = r[39];
		wr(REG_CTRL, {31'h0, sat});
		wr(REG_OPW, op);
		wr(REG_ACC_LO, a[31:0]);
		wr(REG_ACC_HI, {24'h0, a[39:32]});
		wr(REG_FLAGS, {25'h0, f0});
		wr(REG_INSTR, {3'h0, imm, b2, b1, b0});
		check(rs, RESP_OKAY);
		rd(REG_ACC_LO);
		got[31:0] = rd_v;
		rd(REG_ACC_HI);
		got[39:32] = rd_v[7:0];
		check(got, r);
		rd(REG_FLAGS);
		check(rd_v[7:0], {1'b0, f});
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic s_reset();
		rd(REG_ACC_LO);
		check(rd_v, ACC_RST[31:0]);
		rd(REG_FLAGS);
		check(rd_v, 32'h0);
		rd(6'h18);
		check({rs, rd_v}, {RESP_SLVERR, 32'h0});
		wr(6'h3c, 32'h1);
		check(rs, RESP_SLVERR);
		wr(REG_OPW, 32'h1);
		i_host_core_model.wr(REG_INSTR, {8'h00, FN_ADD2, 8'h00, OPC_REG_REG}, 4'h1, rs);
		check(rs, RESP_SLVERR);
		rd(REG_ACC_LO);
		check(rd_v, 32'h0);
	endtask

	task automatic s_add2();
		run(OPC_REG_REG, 8'h12, FN_ADD2, 5'h0, 40'h0000000020, 32'hfffffff0, 1'b0, 7'h0a);
		run(OPC_REG_IND, 8'h34, FN_ADD2, 5'h0, 40'h7fffffffff, 32'h1, 1'b0, 7'h0);
		run(OPC_IDX_IND, 8'h05, FN_ADD2, 5'h0, 40'h007fffff00, 32'h1000, 1'b1, 7'h0);
		run(OPC_REG_REG, 8'h00, FN_ADD2, 5'h0, 40'hff80000000, 32'h80000000, 1'b1, 7'h0);
		run(OPC_REG_REG, 8'h00, FN_ADD2, 5'h0, 40'h0100000000, 32'h1, 1'b0, 7'h0);
	endtask

	task automatic s_rnd();
		run(OPC_REG_REG, 8'h00, FN_RND_IMM, 5'h10, 40'h8012345678, 32'h0, 1'b0, 7'h0);
		run(OPC_REG_REG, 8'h00, FN_RND_IMM, 5'h0, 40'hffffff8000, 32'h0, 1'b0, 7'h0);
		run(OPC_REG_REG, 8'h07, FN_RND_REG, 5'h0, 40'h7fffffffff, 32'h12340010, 1'b0, 7'h0);
		run(OPC_REG_IND, 8'h09, FN_RND_REG, 5'h0, 40'h7fffffffff, 32'h1f, 1'b0, 7'h0);
		run(OPC_REG_IND, 8'h09, FN_RND_REG, 5'h0, 40'h7fffffffff, 32'h14, 1'b1, 7'h0);
	endtask

	task automatic s_trn();
		run(OPC_REG_REG, 8'h00, FN_TRN_IMM, 5'h10, 40'h8000000000, 32'h0, 1'b1, 7'h7f);
		run(OPC_REG_REG, 8'h02, FN_TRN_REG, 5'h0, 40'h7fffffffff, 32'hfffffff3, 1'b1, 7'h11);
		run(OPC_REG_IND, 8'h02, FN_TRN_REG, 5'h0, 40'h0000000001, 32'h1, 1'b0, 7'h0);
	endtask

	// Count of 17 is refused: nothing runs, illegal bit set
	task automatic s_illegal();
		wr(REG_ACC_LO, 32'h12345678);
		wr(REG_INSTR, {3'h0, 5'h11, FN_RND_IMM, 8'h00, OPC_REG_REG});
		check(rs, RESP_OKAY);
		rd(REG_FLAGS);
		check(rd_v[FLAGS_BAD_BIT], 1'b1);
		rd(REG_ACC_LO);
		check(rd_v, 32'h12345678);
	endtask

	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		s_reset();
		s_add2();
		s_rnd();
		s_trn();
		s_illegal();
		stop_test();
	end
endmodule // mac_accumulator_add2_shift_tb
